// [ism_map.vh]
// register map, field positions, reset values and timing counts
`ifndef ISM_MAP_VH
`define ISM_MAP_VH

`define ISM_ADDR_CTRL 8'h00
`define ISM_ADDR_CFG 8'h04
`define ISM_ADDR_STATUS 8'h08
`define ISM_ADDR_TSTAMP 8'h0C
`define ISM_ADDR_EVCOUNT 8'h10
`define ISM_ADDR_EVDATA 8'h14
`define ISM_ADDR_IRQ_STAT 8'h18
`define ISM_ADDR_IRQ_MASK 8'h1C

`define ISM_CTRL_RUN 0
`define ISM_CFG_SINGLE_LSB 0
`define ISM_CFG_SEL_LSB 8
`define ISM_CFG_RESET 32'h00000000
`define ISM_SINGLE_RESET 5'h00

`define ISM_SEL_BOTH0 2'h0
`define ISM_SEL_ON 2'h1
`define ISM_SEL_OFF 2'h2
`define ISM_SEL_BOTH 2'h3

`define ISM_ST_INTER 2'h0
`define ISM_ST_OPEN 2'h1
`define ISM_ST_CLOSED 2'h2
`define ISM_ST_BAD 2'h3

`define ISM_IRQ_STORED 0
`define ISM_IRQ_LOST 1
`define ISM_IRQ_CHANGE 2

`define ISM_NUM_INST 5
`define ISM_NUM_EV 40
`define ISM_BUF_DEPTH 16
`define ISM_BUF_AW 4

`define ISM_CLK_NS 10
`define ISM_STAMP_NS 1000000
`define ISM_MS_CYCLES (`ISM_STAMP_NS / `ISM_CLK_NS)

`endif

// [ism_decode.v]
// one indicator instance: input synchroniser, status decode, edge events
`timescale 1ns/1ps
`include "ism_map.vh"

module ism_decode (
	input wire clock,
	input wire rst,
	input wire open_pin,
	input wire close_pin,
	input wire single_mode,
	output wire [1:0] status,
	output wire [7:0] ev
);
	reg [1:0] open_sync_q;
	reg [1:0] close_sync_q;
	reg [1:0] status_q;
	reg [1:0] status_d;
	reg [1:0] prev_q;
	wire open_s;
	wire close_s;
	wire [3:0] cur_hot;
	wire [3:0] prev_hot;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			open_sync_q <= 2'h0;
			close_sync_q <= 2'h0;
		end else begin
			open_sync_q <= {open_sync_q[0], open_pin};
			close_sync_q <= {close_sync_q[0], close_pin};
		end
	end

	assign open_s = open_sync_q[1];
	// one-input monitoring: the closed contact is the inverted open one
	assign close_s = single_mode ? ~open_sync_q[1] : close_sync_q[1];

	always @* begin
		if (open_s && close_s)
			status_d = `ISM_ST_BAD;
		else if (open_s)
			status_d = `ISM_ST_OPEN;
		else if (close_s)
			status_d = `ISM_ST_CLOSED;
		else
			status_d = `ISM_ST_INTER;
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			status_q <= `ISM_ST_INTER;
			prev_q <= `ISM_ST_INTER;
		end else begin
			status_q <= status_d;
			prev_q <= status_q;
		end
	end

	assign status = status_q;
	assign cur_hot = 4'h1 << status_q;
	assign prev_hot = 4'h1 << prev_q;

	// ev[2s+1] = state s became active, ev[2s] = state s went inactive
	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_ev
			assign ev[2*s+1] = cur_hot[s] & ~prev_hot[s];
			assign ev[2*s] = prev_hot[s] & ~cur_hot[s];
		end
	endgenerate
endmodule

// [ism_evbuf.v]
// shared event buffer, a small first-in first-out store
`timescale 1ns/1ps
`include "ism_map.vh"

module ism_evbuf (
	input wire clock,
	input wire rst,
	input wire wr_en,
	input wire [31:0] din,
	input wire rd_en,
	output wire [31:0] dout,
	output wire [4:0] count,
	output wire full,
	output wire empty
);
	reg [31:0] mem [0:`ISM_BUF_DEPTH-1];
	reg [`ISM_BUF_AW-1:0] wr_ptr_q;
	reg [`ISM_BUF_AW-1:0] rd_ptr_q;
	reg [4:0] count_q;
	wire do_wr;
	wire do_rd;

	assign full = (count_q == 5'h10);
	assign empty = (count_q == 5'h00);
	assign do_wr = wr_en & ~full;
	assign do_rd = rd_en & ~empty;
	assign dout = empty ? 32'h00000000 : mem[rd_ptr_q];
	assign count = count_q;

	always @(posedge clock) begin
		if (do_wr)
			mem[wr_ptr_q] <= din;
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr_q <= 4'h0;
			rd_ptr_q <= 4'h0;
			count_q <= 5'h00;
		end else begin
			if (do_wr)
				wr_ptr_q <= wr_ptr_q + 4'h1;
			if (do_rd)
				rd_ptr_q <= rd_ptr_q + 4'h1;
			if (do_wr && !do_rd)
				count_q <= count_q + 5'h01;
			else if (do_rd && !do_wr)
				count_q <= count_q - 5'h01;
		end
	end
endmodule

// [ism_top.v]
// indicator status monitor: five instances, event buffer, AHB-Lite slave
`timescale 1ns/1ps
`include "ism_map.vh"

// Operation
// - status codes: intermediate 0, open 1, closed 2, bad 3
// - neither input active gives intermediate
// - both inputs active gives bad
// - position inputs are active high
// - ON and OFF events per state into buffer
// - event time stamps count milliseconds
// - select ON only, OFF only, or both
// - current status reported as ON events when started, except with OFF only selected
// - no command output, only status and events
// - single input mode inverts open into closed
// - five independent monitoring instances
// - settings change only while stopped; the interrupt mask can still be written while running
module ism_top #(
	parameter integer MS_CYCLES = `ISM_MS_CYCLES
) (
	input wire clock,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire [31:0] hrdata,
	output wire hresp,
	input wire [4:0] open_in,
	input wire [4:0] close_in,
	output wire [9:0] status_out,
	output wire irq
);
	localparam integer MS_LAST_I = MS_CYCLES - 1;
	localparam [16:0] MS_LAST = MS_LAST_I[16:0];

	// bus slave state
	reg [7:0] a_addr_q;
	reg a_wr_q;
	reg dph_q;
	reg hreadyout_q;
	reg [31:0] hrdata_q;
	reg hresp_q;
	reg [31:0] rdata;
	wire acc;
	wire wr_stb;
	wire rd_stb;

	// software-visible state
	reg run_q;
	reg run_prev_q;
	reg [4:0] single_q;
	reg [1:0] sel_q;
	reg [2:0] ist_q;
	reg [2:0] ist_d;
	reg [2:0] imask_q;
	reg irq_q;

	// time base
	reg [16:0] tick_q;
	reg [31:0] ms_q;

	// event path
	// slot index: 8 x instance + 2 x state + ON flag
	reg [39:0] pend_q;
	reg [39:0] pend_d;
	reg [39:0] clr;
	reg [5:0] pick_idx;
	reg pick_vld;
	integer k;
	wire [39:0] ev_raw;
	wire [39:0] rep;
	wire [39:0] allow;
	wire [39:0] new_ev;
	wire [9:0] stat;
	wire run_rise;
	wire grant;
	wire lost;
	wire pop;
	wire [31:0] entry;
	wire [31:0] buf_dout;
	wire [4:0] buf_count;
	wire buf_full;
	wire allow_on;
	wire allow_off;

	// each instance owns its synchroniser, decode and edge detection
	genvar i;
	generate
		for (i = 0; i < `ISM_NUM_INST; i = i + 1) begin : g_inst
			ism_decode u_dec (
				.clock(clock),
				.rst(rst),
				.open_pin(open_in[i]),
				.close_pin(close_in[i]),
				.single_mode(single_q[i]),
				.status(stat[2*i+1:2*i]),
				.ev(ev_raw[8*i+7:8*i])
			);
			// start of operation: one ON event for the state now held
			assign rep[8*i+7:8*i] = run_rise ?
				(8'h02 << {stat[2*i+1:2*i], 1'b0}) : 8'h00;
		end
	endgenerate

	// status leaves straight from the decoder flops; nothing else goes out
	assign status_out = stat;

	// AHB-Lite: one wait state so read data comes from a flop
	// a transfer is taken when selected, active and the bus is ready;
	// hreadyout drops for exactly one cycle of its data phase
	// hresp stays OKAY; unmapped offsets read zero and ignore writes
	assign acc = hsel & htrans[1] & hready;
	assign wr_stb = dph_q & a_wr_q;
	assign rd_stb = dph_q & ~a_wr_q;
	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			a_addr_q <= 8'h00;
			a_wr_q <= 1'b0;
			dph_q <= 1'b0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hresp_q <= 1'b0;
			if (acc) begin
				a_addr_q <= haddr[7:0];
				a_wr_q <= hwrite;
				dph_q <= 1'b1;
				hreadyout_q <= 1'b0;
			end else if (dph_q) begin
				dph_q <= 1'b0;
				hreadyout_q <= 1'b1;
			end
		end
	end

	always @* begin
		if (a_addr_q == `ISM_ADDR_CTRL)
			rdata = {31'h00000000, run_q};
		else if (a_addr_q == `ISM_ADDR_CFG)
			rdata = {22'h000000, sel_q, 3'h0, single_q};
		else if (a_addr_q == `ISM_ADDR_STATUS)
			rdata = {22'h000000, stat};
		else if (a_addr_q == `ISM_ADDR_TSTAMP)
			rdata = ms_q;
		else if (a_addr_q == `ISM_ADDR_EVCOUNT)
			rdata = {27'h0000000, buf_count};
		else if (a_addr_q == `ISM_ADDR_EVDATA)
			rdata = buf_dout;
		else if (a_addr_q == `ISM_ADDR_IRQ_STAT)
			rdata = {29'h00000000, ist_q};
		else if (a_addr_q == `ISM_ADDR_IRQ_MASK)
			rdata = {29'h00000000, imask_q};
		else
			rdata = 32'h00000000;
	end

	// hrdata holds the last read value until the next read
	always @(posedge clock or posedge rst) begin
		if (rst)
			hrdata_q <= 32'h00000000;
		else if (rd_stb)
			hrdata_q <= rdata;
	end

	// reading the event data register pops the oldest entry
	assign pop = rd_stb & (a_addr_q == `ISM_ADDR_EVDATA);

	// control and configuration
	// clearing run stops new events; stored entries stay readable
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			run_q <= 1'b0;
			run_prev_q <= 1'b0;
			single_q <= `ISM_SINGLE_RESET;
			sel_q <= `ISM_SEL_BOTH0;
			imask_q <= 3'h0;
		end else begin
			run_prev_q <= run_q;
			if (wr_stb && a_addr_q == `ISM_ADDR_CTRL)
				run_q <= hwdata[`ISM_CTRL_RUN];
			// settings are frozen while the monitor runs
			if (wr_stb && a_addr_q == `ISM_ADDR_CFG && !run_q) begin
				single_q <= hwdata[`ISM_CFG_SINGLE_LSB+4:`ISM_CFG_SINGLE_LSB];
				sel_q <= hwdata[`ISM_CFG_SEL_LSB+1:`ISM_CFG_SEL_LSB];
			end
			if (wr_stb && a_addr_q == `ISM_ADDR_IRQ_MASK)
				imask_q <= hwdata[2:0];
		end
	end

	assign run_rise = run_q & ~run_prev_q;

	// millisecond time stamp
	// counts from reset, one step per MS_CYCLES clock periods
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_q <= 17'h00000;
			ms_q <= 32'h00000000;
		end else if (tick_q == MS_LAST) begin
			tick_q <= 17'h00000;
			ms_q <= ms_q + 32'h00000001;
		end else begin
			tick_q <= tick_q + 17'h00001;
		end
	end

	// edge selection: odd bits are ON events, even bits OFF events
	// select 0 is treated like 3: both kinds are stored
	assign allow_on = (sel_q != `ISM_SEL_OFF);
	assign allow_off = (sel_q != `ISM_SEL_ON);
	generate
		for (i = 0; i < `ISM_NUM_EV / 2; i = i + 1) begin : g_allow
			assign allow[2*i+1] = allow_on;
			assign allow[2*i] = allow_off;
		end
	endgenerate

	// nothing is queued while the monitor is stopped
	assign new_ev = (ev_raw | rep) & allow & {40{run_q}};

	// lowest pending index goes first, one entry per clock
	// while the buffer is full the pending slots simply wait
	always @* begin
		pick_idx = 6'h00;
		pick_vld = 1'b0;
		for (k = `ISM_NUM_EV - 1; k >= 0; k = k - 1) begin
			if (pend_q[k]) begin
				pick_idx = k[5:0];
				pick_vld = 1'b1;
			end
		end
	end

	assign grant = pick_vld & ~buf_full;

	always @* begin
		clr = 40'h0000000000;
		if (grant)
			clr[pick_idx] = 1'b1;
		pend_d = (pend_q & ~clr) | new_ev;
	end

	// an event whose slot is still waiting is lost
	assign lost = |(new_ev & pend_q & ~clr);

	always @(posedge clock or posedge rst) begin
		if (rst)
			pend_q <= 40'h0000000000;
		else
			pend_q <= pend_d;
	end

	// entry: stamp, instance, state, ON flag
	assign entry = {ms_q[23:0], pick_idx[5:3], pick_idx[2:1], pick_idx[0],
		2'h0};

	ism_evbuf u_buf (
		.clock(clock),
		.rst(rst),
		.wr_en(grant),
		.din(entry),
		.rd_en(pop),
		.dout(buf_dout),
		.count(buf_count),
		.full(buf_full),
		.empty()
	);

	// sticky interrupt status, write one to clear, new event wins
	always @* begin
		ist_d = ist_q;
		if (wr_stb && a_addr_q == `ISM_ADDR_IRQ_STAT)
			ist_d = ist_q & ~hwdata[2:0];
		if (grant)
			ist_d[`ISM_IRQ_STORED] = 1'b1;
		if (lost)
			ist_d[`ISM_IRQ_LOST] = 1'b1;
		if (|ev_raw)
			ist_d[`ISM_IRQ_CHANGE] = 1'b1;
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ist_q <= 3'h0;
			irq_q <= 1'b0;
		end else begin
			ist_q <= ist_d;
			irq_q <= |(ist_q & imask_q);
		end
	end

	// registered, so irq follows an unmasked status bit by one cycle
	assign irq = irq_q;
endmodule

// [ism_contacts.sv]
// position contact model for the five indicators
`timescale 1ns/1ps
module ism_contacts (
	input wire [9:0] pos,
	input wire [4:0] single,
	output reg [4:0] open_in,
	output reg [4:0] close_in
);
	integer i;
	always @* begin
		for (i = 0; i < 5; i = i + 1) begin
			open_in[i] = pos[2*i];
			close_in[i] = single[i] ? !pos[2*i] : pos[2*i+1];
		end
	end
endmodule

// [ism_top_sva.sv]
// checker for bus timing and status decode
`timescale 1ns/1ps
module ism_top_chk (
	input wire clock,
	input wire rst,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire hresp,
	input wire [4:0] open_in,
	input wire [9:0] status_out,
	input wire irq
);
	reg [1:0] up_q;
	wire tk = hsel && htrans[1] && hready;
	wire [1:0] s0 = status_out[1:0];
	wire up = up_q == 2'h3;
	always @(posedge clock or posedge rst) begin
		if (rst)
			up_q <= 2'h0;
		else if (!up)
			up_q <= up_q + 2'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_wait_state: assert property (tk |=> !hreadyout ##1 hreadyout)
		else $error("wait state wrong");
	a_ready_cause: assert property (!hreadyout |-> $past(tk))
		else $error("stray wait state");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_rdata_hold: assert property (!$past(tk && !hwrite, 2) |->
		$stable(hrdata))
		else $error("read data moved");
	a_inter_code: assert property (up && s0 == 2'h0 |->
		!$past(open_in[0], 3)) else $error("intermediate wrong");
	a_open_code: assert property (up && s0 == 2'h1 |->
		$past(open_in[0], 3)) else $error("open wrong");
	a_closed_code: assert property (up && s0 == 2'h2 |->
		!$past(open_in[0], 3)) else $error("closed wrong");
	a_bad_code: assert property (up && s0 == 2'h3 |->
		$past(open_in[0], 3)) else $error("bad wrong");
	c_bad: cover property (s0 == 2'h3);
	c_read: cover property (tk && !hwrite);
	c_irq: cover property ($rose(irq));
endmodule
bind ism_top ism_top_chk i_chk (.clock(clock), .rst(rst), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.open_in(open_in), .status_out(status_out), .irq(irq));

// [testbench.sv]
// testbench for the indicator status monitor
`timescale 1ns/1ps
module testbench;
	reg clock = 0;
	reg rst = 1;
	reg hsel = 0;
	reg [31:0] haddr = 0;
	reg [1:0] htrans = 0;
	reg hwrite = 0;
	reg [31:0] hwdata = 0;
	reg [9:0] pos = 0;
	reg [4:0] single = 0;
	reg [31:0] lf = 32'h0001797A;
	reg [31:0] rd;
	reg [31:0] t0;
	wire hready;
	wire [31:0] hrdata;
	wire hresp;
	wire [4:0] open_in;
	wire [4:0] close_in;
	wire [9:0] status_out;
	wire irq;
	integer mismatches = 0;
	integer checked = 0;
	integer i;
	integer k;
	always #5 clock = ~clock;
	ism_top #(.MS_CYCLES(50)) i_dut (.clock(clock), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hrdata(hrdata), .hresp(hresp), .open_in(open_in),
		.close_in(close_in), .status_out(status_out), .irq(irq));
	ism_contacts i_sw (.pos(pos), .single(single), .open_in(open_in),
		.close_in(close_in));
	function [31:0] nxt(input [31:0] x);
		nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function [9:0] exp_st(input [9:0] p, input [4:0] s);
		integer j;
		for (j = 0; j < 5; j = j + 1)
			exp_st[2*j+:2] = s[j] ? (p[2*j] ? 2'h1 : 2'h2) : p[2*j+:2];
	endfunction
	task test_done;
		begin
			$display("checks %0d mismatches %0d", checked, mismatches);
			if (mismatches == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t: %h vs %h", $time, seen, exp);
			end
		end
	endtask
	// hready is looked at mid-cycle, where it stands for the coming edge
	task waitrdy;
		begin
			k = 0;
			@(negedge clock);
			while (hready !== 1'b1 && k < 20) begin
				k = k + 1;
				@(negedge clock);
			end
			if (hready === 1'b1)
				@(posedge clock);
			else begin
				mismatches = mismatches + 1;
				test_done;
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			haddr <= {24'h000000, a};
			htrans <= 2'h2;
			hwrite <= w;
			waitrdy;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			waitrdy;
			rd = hrdata;
		end
	endtask
	task event_check(input [7:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk({24'h000000, rd[7:0]}, e);
		end
	endtask
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		event_check(8'h04, 32'h0);
		event_check(8'h1C, 32'h0);
		bus(1'b1, 8'h40, 32'hFFFFFFFF);
		event_check(8'h40, 32'h0);
		for (i = 0; i < 24; i = i + 1) begin
			lf = nxt(lf);
			pos <= (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : lf[9:0];
			if (i == 12) begin
				single <= lf[14:10];
				bus(1'b1, 8'h04, {27'h0000000, lf[14:10]});
			end
			repeat (4) @(posedge clock);
			chk(status_out, exp_st(pos, single));
			bus(1'b0, 8'h08, 32'h0);
			chk(rd, exp_st(pos, single));
		end
		single <= 5'h00;
		pos <= 10'h000;
		bus(1'b1, 8'h04, 32'h00000100);
		repeat (4) @(posedge clock);
		bus(1'b1, 8'h18, 32'h00000007);
		bus(1'b1, 8'h1C, 32'h00000001);
		bus(1'b1, 8'h00, 32'h00000001);
		repeat (60) @(posedge clock);
		chk(irq, 1'b1);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h5);
		for (i = 0; i < 5; i = i + 1)
			event_check(8'h14, {i[2:0], 5'h04});
		bus(1'b1, 8'h04, 32'h00000200);
		bus(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h00000100);
		pos <= 10'h020;
		repeat (60) @(posedge clock);
		event_check(8'h10, 32'h1);
		event_check(8'h14, 32'h54);
		bus(1'b0, 8'h18, 32'h0);
		chk(rd, 32'h5);
		bus(1'b1, 8'h18, 32'h00000007);
		repeat (3) @(posedge clock);
		chk(irq, 1'b0);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h04, 32'h00000200);
		bus(1'b1, 8'h1C, 32'h0);
		bus(1'b1, 8'h00, 32'h00000001);
		pos <= 10'h010;
		repeat (60) @(posedge clock);
		chk(irq, 1'b0);
		event_check(8'h10, 32'h1);
		event_check(8'h14, 32'h50);
		event_check(8'h14, 32'h0);
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h04, 32'h00000300);
		bus(1'b1, 8'h00, 32'h00000001);
		pos <= 10'h013;
		repeat (60) @(posedge clock);
		event_check(8'h10, 32'h7);
		bus(1'b0, 8'h0C, 32'h0);
		t0 = rd;
		repeat (47) @(posedge clock);
		bus(1'b0, 8'h0C, 32'h0);
		chk(rd - t0, 32'h1);
		test_done;
	end
endmodule
